/* src/timer_capture_compare_config.sv */
// Capture/compare register and mode configuration of a 16-bit timer
`timescale 1ns/1ps
`include "tcc_consts.svh"
module timer_capture_compare_config #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic [2:0]         s_axi_awprot,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,
   input  wire logic [2:0]         s_axi_arprot,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // Counter state from the neighbouring counter, same clock
   input  wire logic [15:0]        count_value,
   // External edge pin
   input  wire logic               edge_pin,
   // Controls to the neighbouring counter
   output logic                    count_step,
   output logic                    capture_reload,
   output logic [15:0]             capture_compare_value,
   output logic [7:0]              timer_configuration,
   // Flag and interrupt
   output logic                    capture_compare_flag,
   output logic                    irq
);

   edge_event_if ev ();

   edge_sync_detect u_edge (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .edge_pin (edge_pin),
      .ev       (ev)
   );

   logic [15:0]                 ccv_q;
   logic [7:0]                  cfg_q;
   logic [`TCC_EVT_W-1:0]       status_q;
   logic [`TCC_EVT_W-1:0]       mask_q;
   logic [`TCC_EVT_W-1:0]       evt_set;
   logic                        awready_q;
   logic                        wready_q;
   logic                        aw_held_q;
   logic                        w_held_q;
   logic [ADDR_W-1:0]           aw_addr_q;
   logic [31:0]                 w_data_q;
   logic [3:0]                  w_strb_q;
   logic                        bvalid_q;
   logic [1:0]                  bresp_q;
   logic                        arready_q;
   logic                        rvalid_q;
   logic [31:0]                 rdata_q;
   logic [1:0]                  rresp_q;
   logic                        step_q;
   logic                        capt_q;
   logic                        irq_q;
   logic                        eq_full_q;
   logic                        eq_high_q;
   logic                        eq_low_q;

   // Mode decoding
   logic                        counter_mode;
   logic                        dual_mode;
   tcc_pkg::edge_sel_t          edge_sel;
   logic                        edge_hit;
   logic                        capture_mode;
   logic                        compare_mode;
   logic                        capture_now;
   logic                        eq_full;
   logic                        eq_high;
   logic                        eq_low;
   logic                        match_now;
   logic                        low_match_now;

   assign counter_mode = cfg_q[`TCC_CFG_CT_BIT];
   assign dual_mode    = cfg_q[`TCC_CFG_DUAL_BIT];
   assign edge_sel     = tcc_pkg::edge_sel_t'(
                            cfg_q[`TCC_CFG_EDGE_HI:`TCC_CFG_EDGE_LO]);

   // Edge qualification by the selected edge
   always_comb begin
      case (edge_sel)
         tcc_pkg::EDGE_RISE: edge_hit = ev.rise;
         tcc_pkg::EDGE_FALL: edge_hit = ev.fall;
         tcc_pkg::EDGE_BOTH: edge_hit = ev.rise | ev.fall;
         default:            edge_hit = 1'b0;
      endcase
   end

   assign capture_mode = !counter_mode
                         && (edge_sel != tcc_pkg::EDGE_NONE);
   assign compare_mode = !counter_mode
                         && (edge_sel == tcc_pkg::EDGE_NONE);
   assign capture_now  = capture_mode && edge_hit;

   // Equality seen as a new event only on its first cycle, so a count
   // that parks on the compare value cannot hold the flag set forever
   assign eq_full = !dual_mode && (count_value == ccv_q);
   assign eq_high = dual_mode && (count_value[15:8] == ccv_q[15:8]);
   assign eq_low  = dual_mode && (count_value[7:0] == ccv_q[7:0]);
   assign match_now = compare_mode
                      && ((eq_full && !eq_full_q)
                          || (eq_high && !eq_high_q));
   // Low timer compares in dual mode only, whatever the counter and edge bits say
   assign low_match_now = eq_low && !eq_low_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eq_full_q <= 1'b0;
         eq_high_q <= 1'b0;
         eq_low_q  <= 1'b0;
      end else begin
         eq_full_q <= eq_full;
         eq_high_q <= eq_high;
         eq_low_q  <= eq_low;
      end
   end

   // Bus write side
   logic                        do_write;
   logic [5:0]                  w_index;
   logic                        w_mapped;

   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign w_index  = aw_addr_q[7:2];
   assign w_mapped = (aw_addr_q[1:0] == 2'h0)
                     && ((w_index == `TCC_CCV_INDEX)
                         || (w_index == `TCC_CFG_INDEX)
                         || (w_index == `TCC_HIGH_INDEX)
                         || (w_index == `TCC_STATUS_INDEX)
                         || (w_index == `TCC_MASK_INDEX));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && awready_q) begin
         awready_q <= 1'b0;
         aw_held_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (bvalid_q && s_axi_bready) begin
         awready_q <= 1'b1;
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_q <= 1'b1;
         w_held_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && wready_q) begin
         wready_q <= 1'b0;
         w_held_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (bvalid_q && s_axi_bready) begin
         wready_q <= 1'b1;
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `TCC_RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q  <= w_mapped ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   logic wr_ccv;
   logic wr_cfg;
   logic wr_high;
   logic wr_status;
   logic wr_mask;

   assign wr_ccv    = do_write && w_mapped && (w_index == `TCC_CCV_INDEX);
   assign wr_cfg    = do_write && w_mapped && (w_index == `TCC_CFG_INDEX);
   assign wr_high   = do_write && w_mapped && (w_index == `TCC_HIGH_INDEX);
   assign wr_status = do_write && w_mapped
                      && (w_index == `TCC_STATUS_INDEX);
   assign wr_mask   = do_write && w_mapped && (w_index == `TCC_MASK_INDEX);

   // Capture/compare storage; the upper byte doubles as the high-byte
   // register in dual mode. A capture beats a write in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ccv_q <= `TCC_CCV_RESET;
      end else if (capture_now && !dual_mode) begin
         ccv_q <= count_value;
      end else if (capture_now && dual_mode) begin
         ccv_q[15:8] <= count_value[15:8];
      end else begin
         if (wr_ccv && w_strb_q[0]) begin
            ccv_q[7:0] <= w_data_q[7:0];
         end
         if (wr_ccv && w_strb_q[1] && !dual_mode) begin
            ccv_q[15:8] <= w_data_q[15:8];
         end
         if (wr_high && w_strb_q[0] && dual_mode) begin
            ccv_q[15:8] <= w_data_q[7:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= `TCC_CFG_RESET;
      end else if (wr_cfg && w_strb_q[0]) begin
         cfg_q <= w_data_q[7:0];
      end
   end

   // Sticky events: a set in the clearing cycle survives the clear
   assign evt_set[`TCC_EVT_CC_BIT]  = match_now || capture_now;
   assign evt_set[`TCC_EVT_LOW_BIT] = low_match_now;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= `TCC_EVT_RESET;
      end else if (wr_status && w_strb_q[0]) begin
         status_q <= (status_q & ~w_data_q[`TCC_EVT_W-1:0]) | evt_set;
      end else begin
         status_q <= status_q | evt_set;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= `TCC_EVT_RESET;
      end else if (wr_mask && w_strb_q[0]) begin
         mask_q <= w_data_q[`TCC_EVT_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |((status_q | evt_set) & mask_q);
      end
   end

   // Pulses to the neighbouring counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_q <= 1'b0;
         capt_q <= 1'b0;
      end else begin
         step_q <= counter_mode && edge_hit;
         capt_q <= capture_now;
      end
   end

   // Bus read side; reads have no side effects
   logic [5:0]  r_index;
   logic [31:0] r_word;
   logic        r_mapped;

   assign r_index = s_axi_araddr[7:2];

   always_comb begin
      r_word   = 32'h0000_0000;
      r_mapped = (s_axi_araddr[1:0] == 2'h0);
      if (r_index == `TCC_CCV_INDEX) begin
         r_word[15:0] = dual_mode ? {8'h00, ccv_q[7:0]} : ccv_q;
      end else if (r_index == `TCC_CFG_INDEX) begin
         r_word[7:0] = cfg_q;
      end else if (r_index == `TCC_HIGH_INDEX) begin
         r_word[7:0] = dual_mode ? ccv_q[15:8] : 8'h00;
      end else if (r_index == `TCC_STATUS_INDEX) begin
         r_word[`TCC_EVT_W-1:0] = status_q;
      end else if (r_index == `TCC_MASK_INDEX) begin
         r_word[`TCC_EVT_W-1:0] = mask_q;
      end else begin
         r_mapped = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `TCC_RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= r_mapped ? r_word : 32'h0000_0000;
         rresp_q   <= r_mapped ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   assign s_axi_awready         = awready_q;
   assign s_axi_wready          = wready_q;
   assign s_axi_bvalid          = bvalid_q;
   assign s_axi_bresp           = bresp_q;
   assign s_axi_arready         = arready_q;
   assign s_axi_rvalid          = rvalid_q;
   assign s_axi_rdata           = rdata_q;
   assign s_axi_rresp           = rresp_q;
   assign count_step            = step_q;
   assign capture_reload        = capt_q;
   assign capture_compare_value = ccv_q;
   assign timer_configuration   = cfg_q;
   assign capture_compare_flag  = status_q[`TCC_EVT_CC_BIT];
   assign irq                   = irq_q;

endmodule

/* src/tcc_consts.svh */
// Offsets, field positions and reset values of the capture/compare block
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// Register indices; byte address is four times the index
`define TCC_CCV_INDEX     6'h0e
`define TCC_CFG_INDEX     6'h0f
`define TCC_HIGH_INDEX    6'h10
`define TCC_STATUS_INDEX  6'h11
`define TCC_MASK_INDEX    6'h12

// Reset values
`define TCC_CCV_RESET     16'h0000
`define TCC_CFG_RESET     8'h00
`define TCC_EVT_RESET     2'h0

// Fields of timer_configuration
`define TCC_CFG_CT_BIT    0
`define TCC_CFG_EDGE_LO   1
`define TCC_CFG_EDGE_HI   2
`define TCC_CFG_DUAL_BIT  3

// Event bits of status and mask
`define TCC_EVT_CC_BIT    0
`define TCC_EVT_LOW_BIT   1
`define TCC_EVT_W         2

// Bus answers
`define TCC_RESP_OKAY     2'h0
`define TCC_RESP_SLVERR   2'h2

`endif

/* src/tcc_pkg.sv */
// Types shared by the capture/compare block
package tcc_pkg;

   typedef enum logic [1:0] {
      EDGE_NONE,
      EDGE_RISE,
      EDGE_FALL,
      EDGE_BOTH
   } edge_sel_t;

endpackage

/* src/edge_event_if.sv */
// Edge events passed from the pin synchroniser to the register block
`timescale 1ns/1ps
interface edge_event_if;
   logic rise;
   logic fall;

   modport src  (output rise, output fall);
   modport sink (input  rise, input  fall);
endinterface

/* src/edge_sync_detect.sv */
// Two-flop synchroniser and edge detector for the external edge input
`timescale 1ns/1ps
module edge_sync_detect (
   // Clock and reset
   input  wire logic  aclk,
   input  wire logic  aresetn,
   // External pin
   input  wire logic  edge_pin,
   // Detected edges
   edge_event_if.src  ev
);

   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic rise_q;
   logic fall_q;

   // First stage is read only by the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= edge_pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // One pulse per edge, so each edge acts exactly once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         rise_q <= sync_q & ~prev_q;
         fall_q <= ~sync_q & prev_q;
      end
   end

   assign ev.rise = rise_q;
   assign ev.fall = fall_q;

endmodule

/* bench/edge_source.sv */
// Model of the external edge pin that feeds the capture/compare block
`timescale 1ns/1ps
module edge_source (
   // Clock
   input  wire logic  aclk,
   // Pin
   output logic       edge_pin
);
   initial begin
      edge_pin = 1'b0;
   end

   // Each level is held 8 cycles, well past the two-cycle spacing and
   // the four-edge pipeline, so each change yields one whole action
   task automatic set_level(input logic v);
      @(posedge aclk);
      edge_pin <= v;
      repeat (8) @(posedge aclk);
   endtask
endmodule

/* bench/tcc_checker_assertions.sv */
// Assertions on the ports of the capture/compare block
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_checker #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // Register bus
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   // Counter side
   input wire logic [15:0]       count_value,
   input wire logic              count_step,
   input wire logic              capture_reload,
   input wire logic [15:0]       capture_compare_value,
   input wire logic [7:0]        timer_configuration,
   input wire logic              capture_compare_flag
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   reset_clear_a: assert property ($rose(aresetn) |->
      capture_compare_value == 16'h0000 && timer_configuration == 8'h00)
      else $error("registers not clear after reset");
   step_mode_a: assert property (count_step |->
      timer_configuration[0] && timer_configuration[2:1] != 2'h0)
      else $error("count step outside counter mode");
   capture_mode_a: assert property (capture_reload |->
      !timer_configuration[0] && timer_configuration[2:1] != 2'h0)
      else $error("capture outside timer capture mode");
   step_pulse_a: assert property (count_step |=> !count_step)
      else $error("count step longer than one cycle");
   capture_flag_a: assert property (capture_reload |->
      ##[0:1] capture_compare_flag)
      else $error("capture did not raise flag");
   capture_value_a: assert property (
      capture_reload && !timer_configuration[3] |->
      capture_compare_value == $past(count_value))
      else $error("captured value differs from count");
   dual_read_a: assert property (
      s_axi_arvalid && s_axi_arready && timer_configuration[3] &&
      s_axi_araddr == ADDR_W'({`TCC_CCV_INDEX, 2'b00}) |=>
      s_axi_rdata[15:8] == 8'h00)
      else $error("upper byte visible in dual mode");
   match_flag_a: assert property (
      timer_configuration[3:0] == 4'h0 &&
      count_value == capture_compare_value &&
      $past(count_value) != $past(capture_compare_value) |->
      ##[0:3] capture_compare_flag)
      else $error("compare match did not raise flag");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped before taken");
endmodule

bind timer_capture_compare_config tcc_checker #(.ADDR_W(ADDR_W)) tcc_checker_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .count_value(count_value),
   .count_step(count_step), .capture_reload(capture_reload),
   .capture_compare_value(capture_compare_value),
   .timer_configuration(timer_configuration),
   .capture_compare_flag(capture_compare_flag));

/* bench/testbench.sv */
// Self-checking bench for the capture/compare block
`timescale 1ns/1ps
`include "tcc_consts.svh"
module testbench;
   localparam logic [7:0] A_CCV  = {`TCC_CCV_INDEX, 2'b00};
   localparam logic [7:0] A_CFG  = {`TCC_CFG_INDEX, 2'b00};
   localparam logic [7:0] A_HIGH = {`TCC_HIGH_INDEX, 2'b00};
   localparam logic [7:0] A_STAT = {`TCC_STATUS_INDEX, 2'b00};
   localparam logic [7:0] A_MASK = {`TCC_MASK_INDEX, 2'b00};
   logic        aclk, aresetn, edge_pin, count_step, capture_reload;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, timer_configuration;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, capture_compare_flag, irq;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [15:0] count_value, capture_compare_value;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp, sel;
   logic [3:0]  s_axi_wstrb;
   int          n_mismatch, checked, n_step, n_cap, s0, c0, ex;

   timer_capture_compare_config #(.ADDR_W(8)) timer_capture_compare_config_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .count_value(count_value), .edge_pin(edge_pin),
      .count_step(count_step), .capture_reload(capture_reload),
      .capture_compare_value(capture_compare_value),
      .timer_configuration(timer_configuration),
      .capture_compare_flag(capture_compare_flag), .irq(irq));
   edge_source edge_source_i (.aclk(aclk), .edge_pin(edge_pin));

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // Counts pulses so a lost or doubled edge action shows up
   always @(posedge aclk) begin
      if (count_step === 1'b1) n_step++;
      if (capture_reload === 1'b1) n_cap++;
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      if (n_mismatch == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic timed_out(input string what);
      n_mismatch++;
      $display("[ERR] %s expected answer seen timeout", what);
      tally_and_finish();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      if (s_axi_bvalid !== 1'b1) timed_out("bvalid");
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         // Late ready makes the slave hold its answer for a cycle
         if (n == 2) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
                 && n < 50);
      if (s_axi_rvalid !== 1'b1) timed_out("rvalid");
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_wstrb = 4'hf;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      count_value = 16'h1000;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(A_CCV); chk("ccv reset", 32'h0, rd);
      rd_reg(A_CFG); chk("cfg reset", 32'h0, rd);
      rd_reg(8'h04); chk("bad resp", 32'h2, {30'h0, resp});
      wr(8'h04, 32'h1);
      chk("bad wresp", 32'h2, {30'h0, resp});
      wr(A_CCV, 32'ha5c3);
      chk("wresp", 32'h0, {30'h0, resp});
      rd_reg(A_CCV); chk("ccv rw", 32'ha5c3, rd);
      s_axi_wstrb <= 4'h1;
      wr(A_CCV, 32'h5678);
      s_axi_wstrb <= 4'hf;
      rd_reg(A_CCV); chk("low strobe", 32'ha578, rd);
      wr(A_CFG, 32'hf0); rd_reg(A_CFG); chk("cfg rw", 32'hf0, rd);
      wr(A_CFG, 32'h08); rd_reg(A_CCV); chk("dual ccv", 32'h78, rd);
      rd_reg(A_HIGH); chk("high byte", 32'ha5, rd);
      wr(A_CCV, 32'h1234); wr(A_HIGH, 32'h77); wr(A_CFG, 32'h0);
      rd_reg(A_CCV); chk("ccv merge", 32'h7734, rd);
      count_value <= 16'h4321;
      // Every counter/timer and edge-select combination, one rise and fall
      for (int i = 0; i < 8; i++) begin
         wr(A_CFG, i);
         sel = i[2:1];
         ex = (sel == 2'h0) ? 0 : (sel == 2'h3) ? 2 : 1;
         s0 = n_step;
         c0 = n_cap;
         edge_source_i.set_level(1'b1);
         edge_source_i.set_level(1'b0);
         chk("steps", i[0] ? ex : 0, n_step - s0);
         chk("captures", i[0] ? 0 : ex, n_cap - c0);
      end
      rd_reg(A_CCV); chk("captured", 32'h4321, rd);
      chk("flag", 32'h1, {31'h0, capture_compare_flag});
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(A_MASK, 32'h1);
      repeat (2) @(posedge aclk);
      chk("irq", 32'h1, {31'h0, irq});
      wr(A_STAT, 32'h1);
      repeat (2) @(posedge aclk);
      chk("flag clear", 32'h0, {30'h0, capture_compare_flag, irq});
      // Compare match in 16-bit timer mode
      count_value <= 16'h00ff;
      wr(A_CFG, 32'h0); wr(A_CCV, 32'h0100); wr(A_STAT, 32'h3);
      count_value <= 16'h0100;
      repeat (4) @(posedge aclk);
      chk("match flag", 32'h1, {31'h0, capture_compare_flag});
      // Low timer still compares while dual mode counts edges
      count_value <= 16'h0001;
      wr(A_CFG, 32'h0b); wr(A_STAT, 32'h3);
      count_value <= 16'h0000;
      repeat (4) @(posedge aclk);
      rd_reg(A_STAT); chk("low match", 32'h1, {31'h0, rd[1]});
      tally_and_finish();
   end
endmodule
